// ### shared/rpmc_pkg.sv
// Constants for the reduced power mode controller
package rpmc_pkg;
    // Power control register
    localparam logic [7:0] PWR_CTRL_ADDR = 8'h87;
    localparam logic [7:0] PWR_CTRL_RST = 8'h00;
    localparam int IDLE_BIT = 0;
    localparam int STOP_OSC_BIT = 1;
    localparam int GEN_FLAG_A_BIT = 2;
    localparam int GEN_FLAG_B_BIT = 3;
    // Watchdog key that disables the watchdog
    localparam logic [2:0] WDOG_OFF_KEY = 3'h5;
    // Timing: 12 oscillator periods per machine cycle
    localparam int OSC_PER_MC = 12;
    localparam int CLK_PER_OSC = 1;
    localparam int RESUME_MC = 3;
    localparam int RESUME_CYCLES = RESUME_MC * OSC_PER_MC * CLK_PER_OSC;
    localparam int EXT_RST_MC = 2;
    localparam int EXT_RST_CYCLES = EXT_RST_MC * OSC_PER_MC * CLK_PER_OSC;
    // Pin counts
    localparam int PWM_CNT = 11;
    localparam int SYNC_CNT = 4;
    // PWM channels whose pins clamp and pattern take over
    localparam int CLAMP_PWM_CH = 8;
    localparam int PAT_PWM_CH = 9;
    localparam logic [5:0] CNT_ZERO = 6'h00;
    localparam logic [5:0] CNT_ONE = 6'h01;
    // Power states
    typedef enum logic [1:0] {
        RPMC_RUN = 2'b00,
        RPMC_IDLE = 2'b01,
        RPMC_DOWN = 2'b10,
        RPMC_RESUME = 2'b11
    } rpmc_state_t;
endpackage : rpmc_pkg

// ### src/rpmc_sync3.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module rpmc_sync3 #(
    // Idle level of the pin, so release of reset shows no false edge
    parameter logic RST_VAL = 1'b1
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Data
    input wire logic d_i,
    output logic q_o
);
    logic s1_r;
    logic s2_r;
    logic s3_r;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            s1_r <= RST_VAL;
            s2_r <= RST_VAL;
            s3_r <= RST_VAL;
        end else begin
            s1_r <= d_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // Change counts only once stages two and three agree
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            q_o <= RST_VAL;
        end else if (s2_r == s3_r) begin
            q_o <= s3_r;
        end
    end
endmodule : rpmc_sync3

// ### src/rpmc_pin_mux.sv
// One shared pin: alternate function over port, with idle and power-down forcing
`timescale 1ns/1ps
module rpmc_pin_mux (
    // Selection
    input wire logic alt_en_i,
    input wire logic push_pull_i,
    input wire logic force_high_i,
    input wire logic force_hiz_i,
    // Sources
    input wire logic alt_val_i,
    input wire logic port_val_i,
    // Pin
    output logic pin_o,
    output logic pin_oe_n_o
);
    logic val;

    always_comb begin
        val = alt_en_i ? alt_val_i : port_val_i;
        pin_o = 1'b1;
        pin_oe_n_o = 1'b1;
        if (force_hiz_i) begin
            pin_o = 1'b1;
            pin_oe_n_o = 1'b1;
        end else if (force_high_i) begin
            // Open drain releases high; push-pull drives high
            pin_o = 1'b1;
            pin_oe_n_o = !push_pull_i;
        end else if (push_pull_i) begin
            pin_o = val;
            pin_oe_n_o = 1'b0;
        end else begin
            // Open drain: only a low is driven
            pin_o = 1'b0;
            pin_oe_n_o = val;
        end
    end
endmodule : rpmc_pin_mux

// ### src/rpmc_top.sv
// Reduced power mode controller: idle, power-down, wake and pin states
`timescale 1ns/1ps
module rpmc_top #(
    parameter int PWM_N = rpmc_pkg::PWM_CNT
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Special-function register port
    input wire logic [7:0] sfr_addr_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    output logic [7:0] sfr_rdata_o,
    output logic sfr_hit_o,
    // Watchdog key and overflow
    input wire logic watchdog_key_bit_2_i,
    input wire logic watchdog_key_bit_1_i,
    input wire logic watchdog_key_bit_0_i,
    input wire logic wdog_overflow_i,
    // Interrupt status from the interrupt controller
    input wire logic irq_pending_i,
    input wire logic ext_b_level_mode_i,
    input wire logic ext_b_enabled_i,
    // Pins from the other party
    input wire logic ext_reset_pin_i,
    input wire logic wake_interrupt_line_i,
    input wire logic osc_stable_i,
    // Configuration
    input wire logic dac_freeze_i,
    input wire logic display_channel_pin_enable_i,
    input wire logic ddc_mode_active_i,
    input wire logic sync_out_sel_i,
    input wire logic pat_clamp_sel_i,
    input wire logic [PWM_N-1:0] pwm_en_i,
    // Peripheral sources
    input wire logic [PWM_N-1:0] pwm_val_i,
    input wire logic [PWM_N-1:0] pwm_port_val_i,
    input wire logic [rpmc_pkg::SYNC_CNT-1:0] sync_val_i,
    input wire logic [rpmc_pkg::SYNC_CNT-1:0] sync_port_val_i,
    input wire logic [1:0] ddc_val_i,
    input wire logic [1:0] ddc_port_val_i,
    // Core and clock control
    output logic cpu_halt_o,
    output logic periph_clk_en_o,
    output logic osc_run_o,
    output logic pwm_reset_o,
    output logic adc_abort_o,
    output logic dac_hold_o,
    output logic sys_reset_o,
    output logic [1:0] power_state_o,
    // Pins
    output logic [PWM_N-1:0] pwm_pin_o,
    output logic [PWM_N-1:0] pwm_pin_oe_n_o,
    output logic [rpmc_pkg::SYNC_CNT-1:0] sync_pin_o,
    output logic [rpmc_pkg::SYNC_CNT-1:0] sync_pin_oe_n_o,
    output logic [1:0] ddc_pin_o,
    output logic [1:0] ddc_pin_oe_n_o
);
    localparam logic [5:0] RESUME_LAST = 6'(rpmc_pkg::RESUME_CYCLES - 1);
    localparam logic [5:0] EXT_RST_LAST = 6'(rpmc_pkg::EXT_RST_CYCLES - 1);

    rpmc_pkg::rpmc_state_t state_r;
    logic [7:0] pwr_ctrl_r;
    logic [5:0] resume_cnt_r;
    logic [5:0] rst_cnt_r;
    logic ext_rst_s;
    logic wake_s;
    logic wdog_off;
    logic pwr_wr;
    logic pd_req;
    logic idle_req;
    logic ext_rst_done;
    logic wake_ok;
    logic in_idle;
    logic in_down;

    // The reset and wake pins pass the filtered synchroniser; osc_stable_i is used unsynchronised
    rpmc_sync3 #(
        .RST_VAL(1'b0)
    ) u_sync_rst (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .d_i(ext_reset_pin_i),
        .q_o(ext_rst_s)
    );
    rpmc_sync3 u_sync_wake (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .d_i(wake_interrupt_line_i),
        .q_o(wake_s)
    );

    assign wdog_off = {watchdog_key_bit_2_i, watchdog_key_bit_1_i,
                       watchdog_key_bit_0_i} == rpmc_pkg::WDOG_OFF_KEY;
    assign pwr_wr = sfr_wr_i && (sfr_addr_i == rpmc_pkg::PWR_CTRL_ADDR);
    assign pd_req = pwr_wr && sfr_wdata_i[rpmc_pkg::STOP_OSC_BIT] && wdog_off;
    // A refused power-down with idle also set still enters idle
    assign idle_req = pwr_wr && sfr_wdata_i[rpmc_pkg::IDLE_BIT] && !pd_req;
    assign ext_rst_done = ext_rst_s && (rst_cnt_r == EXT_RST_LAST);
    assign wake_ok = !wake_s && ext_b_level_mode_i && ext_b_enabled_i && osc_stable_i;
    assign in_idle = (state_r == rpmc_pkg::RPMC_IDLE);
    assign in_down = (state_r == rpmc_pkg::RPMC_DOWN);

    // External reset qualifier: counts held cycles
    always_ff @(posedge clk_sys_i) begin
        if (rst_i || !ext_rst_s) begin
            rst_cnt_r <= rpmc_pkg::CNT_ZERO;
        end else if (rst_cnt_r != EXT_RST_LAST) begin
            rst_cnt_r <= rst_cnt_r + rpmc_pkg::CNT_ONE;
        end
    end

    // Power control register; only writes and resets change its general flag bits
    always_ff @(posedge clk_sys_i) begin
        if (rst_i || ext_rst_done || wdog_overflow_i) begin
            pwr_ctrl_r <= rpmc_pkg::PWR_CTRL_RST;
        end else if (pwr_wr) begin
            pwr_ctrl_r <= sfr_wdata_i;
            if (sfr_wdata_i[rpmc_pkg::STOP_OSC_BIT] && !wdog_off) begin
                pwr_ctrl_r[rpmc_pkg::STOP_OSC_BIT] <= 1'b0;
            end
            if (pd_req) begin
                pwr_ctrl_r[rpmc_pkg::IDLE_BIT] <= 1'b0;
            end
        end else if (in_idle && irq_pending_i) begin
            pwr_ctrl_r[rpmc_pkg::IDLE_BIT] <= 1'b0;
        end else if (in_down && wake_ok) begin
            pwr_ctrl_r[rpmc_pkg::STOP_OSC_BIT] <= 1'b0;
        end
    end

    // Power state machine
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            state_r <= rpmc_pkg::RPMC_RUN;
        end else if (ext_rst_done || wdog_overflow_i) begin
            state_r <= rpmc_pkg::RPMC_RESUME;
        end else begin
            case (state_r)
                rpmc_pkg::RPMC_RUN: begin
                    if (pd_req) begin
                        state_r <= rpmc_pkg::RPMC_DOWN;
                    end else if (idle_req) begin
                        state_r <= rpmc_pkg::RPMC_IDLE;
                    end
                end
                rpmc_pkg::RPMC_IDLE: begin
                    if (irq_pending_i) begin
                        state_r <= rpmc_pkg::RPMC_RESUME;
                    end
                end
                rpmc_pkg::RPMC_DOWN: begin
                    if (wake_ok) begin
                        state_r <= rpmc_pkg::RPMC_RESUME;
                    end
                end
                rpmc_pkg::RPMC_RESUME: begin
                    if (resume_cnt_r == RESUME_LAST) begin
                        state_r <= rpmc_pkg::RPMC_RUN;
                    end
                end
                default: begin
                    state_r <= rpmc_pkg::RPMC_RUN;
                end
            endcase
        end
    end

    // Resume delay counter; a held reset restarts it so timing runs from release
    always_ff @(posedge clk_sys_i) begin
        if (rst_i || ext_rst_done || wdog_overflow_i || state_r != rpmc_pkg::RPMC_RESUME) begin
            resume_cnt_r <= rpmc_pkg::CNT_ZERO;
        end else begin
            resume_cnt_r <= resume_cnt_r + rpmc_pkg::CNT_ONE;
        end
    end

    // Core and clock controls
    always_comb begin
        cpu_halt_o = (state_r != rpmc_pkg::RPMC_RUN);
        periph_clk_en_o = !in_down;
        // Restart by the wake line is analogue and lies outside this block
        osc_run_o = !in_down;
        pwm_reset_o = in_idle || in_down;
        adc_abort_o = in_idle || in_down;
        dac_hold_o = (in_idle || in_down) && dac_freeze_i;
        sys_reset_o = rst_i || ext_rst_done || wdog_overflow_i;
        power_state_o = state_r;
    end

    // Register read port
    always_comb begin
        sfr_hit_o = (sfr_wr_i || sfr_rd_i) && (sfr_addr_i == rpmc_pkg::PWR_CTRL_ADDR);
        sfr_rdata_o = (sfr_rd_i && sfr_hit_o) ? pwr_ctrl_r : 8'h00;
    end

    // PWM pins are open-drain; those with PWM enabled are forced high in both low-power states
    genvar g;
    generate
        for (g = 0; g < PWM_N; g++) begin : g_pwm
            rpmc_pin_mux u_pwm (
                .alt_en_i(pwm_en_i[g]),
                .push_pull_i(1'b0),
                .force_high_i(pwm_en_i[g] && (in_idle || in_down)),
                // Clamp and pattern own these pins even with PWM enabled
                .force_hiz_i(pat_clamp_sel_i && (g == rpmc_pkg::CLAMP_PWM_CH
                    || g == rpmc_pkg::PAT_PWM_CH)),
                .alt_val_i(pwm_val_i[g]),
                .port_val_i(pwm_port_val_i[g]),
                .pin_o(pwm_pin_o[g]),
                .pin_oe_n_o(pwm_pin_oe_n_o[g])
            );
        end
        // Sync outputs 0,1; pattern and clamp 2,3 override their PWM use
        for (g = 0; g < rpmc_pkg::SYNC_CNT; g++) begin : g_sync
            logic sel;
            assign sel = (g < 2) ? sync_out_sel_i : pat_clamp_sel_i;
            rpmc_pin_mux u_sync (
                .alt_en_i(sel),
                .push_pull_i(sel),
                .force_high_i(sel && in_down),
                .force_hiz_i(1'b0),
                .alt_val_i(sync_val_i[g]),
                .port_val_i(sync_port_val_i[g]),
                .pin_o(sync_pin_o[g]),
                .pin_oe_n_o(sync_pin_oe_n_o[g])
            );
        end
        for (g = 0; g < 2; g++) begin : g_ddc
            rpmc_pin_mux u_ddc (
                .alt_en_i(display_channel_pin_enable_i),
                .push_pull_i(1'b0),
                .force_high_i(1'b0),
                .force_hiz_i(display_channel_pin_enable_i &&
                    ((in_idle && !ddc_mode_active_i) || in_down)),
                .alt_val_i(ddc_val_i[g]),
                .port_val_i(ddc_port_val_i[g]),
                .pin_o(ddc_pin_o[g]),
                .pin_oe_n_o(ddc_pin_oe_n_o[g])
            );
        end
    endgenerate

    // Assertions
    chk_pd_locked: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (pwr_wr && !wdog_off && state_r == rpmc_pkg::RPMC_RUN) |=> !in_down)
        else $error("power-down entered with watchdog enabled");
    chk_idle_entry: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (state_r == rpmc_pkg::RPMC_RUN && idle_req && !ext_rst_done && !wdog_overflow_i)
        |=> in_idle && cpu_halt_o)
        else $error("idle not entered after idle write");
    chk_resume_time: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        ($rose(state_r == rpmc_pkg::RPMC_RESUME) && !ext_rst_done && !wdog_overflow_i)
        |-> ##35 (state_r == rpmc_pkg::RPMC_RESUME) ##1 (state_r == rpmc_pkg::RPMC_RUN))
        else $error("resume delay not three machine cycles");
    chk_irq_clears: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (in_idle && irq_pending_i && !pwr_wr && !ext_rst_done && !wdog_overflow_i)
        |=> !pwr_ctrl_r[rpmc_pkg::IDLE_BIT] && state_r == rpmc_pkg::RPMC_RESUME)
        else $error("interrupt did not end idle");
    chk_pwm_high: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (in_idle || in_down) |-> ((pwm_pin_oe_n_o & pwm_en_i) == pwm_en_i)
        && ((pwm_pin_o & pwm_en_i) == pwm_en_i) && pwm_reset_o)
        else $error("pwm pin driven low in low-power state");
    chk_osc_stop: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        in_down |-> !osc_run_o && !periph_clk_en_o)
        else $error("clock still running in power-down");
    chk_pat_priority: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        pat_clamp_sel_i |-> pwm_pin_oe_n_o[rpmc_pkg::CLAMP_PWM_CH]
        && pwm_pin_oe_n_o[rpmc_pkg::PAT_PWM_CH])
        else $error("pwm drives a pin owned by pattern or clamp");
    chk_sync_high: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (in_down && sync_out_sel_i) |-> sync_pin_o[0] && !sync_pin_oe_n_o[0])
        else $error("sync output not high in power-down");
    chk_ddc_hiz: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (in_idle && display_channel_pin_enable_i && !ddc_mode_active_i)
        |-> ddc_pin_oe_n_o == 2'b11)
        else $error("display pins not released in idle");
    chk_ext_reset: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        ext_rst_done |=> pwr_ctrl_r == rpmc_pkg::PWR_CTRL_RST && !in_down)
        else $error("external reset did not clear power control");
    chk_wake_down: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (in_down && wake_ok && !ext_rst_done && !wdog_overflow_i)
        |=> state_r == rpmc_pkg::RPMC_RESUME)
        else $error("wake line did not end power-down");
endmodule : rpmc_top

// ### test/rpmc_partner.sv
// Model of the external reset pin, the wake line and oscillator start-up
`timescale 1ns/1ps
module rpmc_partner #(
    parameter int OSC_DLY = 8
) (
    // Clock and oscillator request
    input wire logic clk_sys_i,
    input wire logic osc_run_i,
    // Pins
    output logic ext_reset_pin_o,
    output logic wake_interrupt_line_o,
    output logic osc_stable_o
);
    int ocnt = 0;
    initial begin
        ext_reset_pin_o = 1'b0;
        wake_interrupt_line_o = 1'b1;
    end
    // Oscillator restarts only when running or woken by the line
    always @(posedge clk_sys_i) begin
        if (!osc_run_i && wake_interrupt_line_o)
            ocnt <= 0;
        else if (ocnt < OSC_DLY)
            ocnt <= ocnt + 1;
    end
    assign osc_stable_o = (ocnt == OSC_DLY);
    task pulse_reset(input int len);
        ext_reset_pin_o = 1'b1;
        repeat (len) @(posedge clk_sys_i);
        #2 ext_reset_pin_o = 1'b0;
    endtask : pulse_reset
    // Line held low until the oscillator is stable
    task wake();
        wake_interrupt_line_o = 1'b0;
        while (!osc_stable_o) @(posedge clk_sys_i);
        @(posedge clk_sys_i);
        #2 wake_interrupt_line_o = 1'b1;
    endtask : wake
endmodule : rpmc_partner

// ### test/reduced_power_mode_control_bench.sv
// Self-checking bench for the reduced power mode controller
`timescale 1ns/1ps
module reduced_power_mode_control_bench;
    logic clk_sys_i, rst_i, sfr_wr_i, sfr_rd_i, sfr_hit_o, wdog_overflow_i;
    logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o;
    logic watchdog_key_bit_2_i, watchdog_key_bit_1_i, watchdog_key_bit_0_i;
    logic irq_pending_i, ext_b_level_mode_i, ext_b_enabled_i;
    logic ext_reset_pin_i, wake_interrupt_line_i, osc_stable_i, dac_freeze_i;
    logic display_channel_pin_enable_i, ddc_mode_active_i, sync_out_sel_i, pat_clamp_sel_i;
    logic [10:0] pwm_en_i, pwm_val_i, pwm_port_val_i, pwm_pin_o, pwm_pin_oe_n_o;
    logic [3:0] sync_val_i, sync_port_val_i, sync_pin_o, sync_pin_oe_n_o;
    logic [1:0] ddc_val_i, ddc_port_val_i, ddc_pin_o, ddc_pin_oe_n_o, power_state_o;
    logic cpu_halt_o, periph_clk_en_o, osc_run_o, pwm_reset_o;
    logic adc_abort_o, dac_hold_o, sys_reset_o;
    int n_rst = 0;
    int n_fail = 0;
    int checks = 0;
    rpmc_top i_dut (.*);
    rpmc_partner i_par (
        .clk_sys_i(clk_sys_i),
        .osc_run_i(osc_run_o),
        .ext_reset_pin_o(ext_reset_pin_i),
        .wake_interrupt_line_o(wake_interrupt_line_i),
        .osc_stable_o(osc_stable_i)
    );
    initial begin
        clk_sys_i = 1'b0;
        forever #25 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) begin
        if (sys_reset_o === 1'b1)
            n_rst <= n_rst + 1;
    end
    task chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task tick(input int n);
        repeat (n) @(posedge clk_sys_i);
        #2;
    endtask : tick
    task wr(input logic [7:0] d);
        sfr_addr_i = 8'h87;
        sfr_wdata_i = d;
        sfr_wr_i = 1'b1;
        tick(1);
        sfr_wr_i = 1'b0;
        // Let an edge pass so a following write never re-raises the strobe at once
        tick(1);
    endtask : wr
    task key(input logic [2:0] k);
        {watchdog_key_bit_2_i, watchdog_key_bit_1_i, watchdog_key_bit_0_i} = k;
    endtask : key
    // Bounded wait for a power state
    task wait_st(input logic [1:0] s);
        for (int i = 0; i < 80 && power_state_o !== s; i++) tick(1);
    endtask : wait_st
    task print_verdict();
        $display("comparisons %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict
    task t_reg();
        chk(sfr_rdata_o, 8'h00);
        chk(sfr_hit_o, 1'b1);
        sfr_addr_i = 8'h88;
        #1;
        chk({sfr_hit_o, sfr_rdata_o}, 9'h000);
        display_channel_pin_enable_i = 1'b0;
        #1;
        chk(ddc_pin_oe_n_o, 2'b10);
        display_channel_pin_enable_i = 1'b1;
        wr(8'h0C);
        chk(sfr_rdata_o, 8'h0C);
        chk(power_state_o, 2'b00);
        wr(8'h00);
        $display("done: register");
    endtask : t_reg
    task t_idle();
        pat_clamp_sel_i = 1'b1;
        sync_val_i = 4'hC;
        #1;
        chk(sync_pin_oe_n_o, 4'h0);
        chk(sync_pin_o, 4'hC);
        chk(pwm_pin_oe_n_o & pwm_en_i, pwm_val_i & pwm_en_i);
        chk(pwm_pin_oe_n_o[9:8], 2'b11);
        wr(8'h0D);
        chk(power_state_o, 2'b01);
        chk({cpu_halt_o, pwm_reset_o, adc_abort_o}, 3'h7);
        chk({dac_hold_o, periph_clk_en_o, osc_run_o}, 3'h7);
        chk(pwm_pin_oe_n_o & pwm_en_i, pwm_en_i);
        chk(pwm_pin_o & pwm_en_i, pwm_en_i);
        sync_val_i = 4'h5;
        #1;
        chk(sync_pin_o, 4'h5);
        chk(ddc_pin_oe_n_o, 2'b11);
        ddc_mode_active_i = 1'b1;
        #1;
        chk({ddc_pin_o, ddc_pin_oe_n_o}, 4'h1);
        tick(5);
        chk({power_state_o, sfr_rdata_o}, 10'h10D);
        irq_pending_i = 1'b1;
        tick(1);
        irq_pending_i = 1'b0;
        chk({power_state_o, sfr_rdata_o}, 10'h30C);
        tick(35);
        chk({power_state_o, cpu_halt_o}, 3'h7);
        tick(1);
        chk({power_state_o, cpu_halt_o}, 3'h0);
        $display("done: idle");
    endtask : t_idle
    task t_lock();
        for (int k = 0; k < 8; k++) begin
            if (k != 5) begin
                key(k[2:0]);
                wr(8'h02);
                chk({power_state_o, sfr_rdata_o}, 10'h000);
            end
        end
        wr(8'h03);
        chk(power_state_o, 2'b01);
        dac_freeze_i = 1'b0;
        #1;
        chk({dac_hold_o, adc_abort_o}, 2'b01);
        dac_freeze_i = 1'b1;
        wdog_overflow_i = 1'b1;
        #1;
        chk(sys_reset_o, 1'b1);
        tick(1);
        wdog_overflow_i = 1'b0;
        chk({power_state_o, sfr_rdata_o}, 10'h300);
        tick(36);
        chk(power_state_o, 2'b00);
        $display("done: lock");
    endtask : t_lock
    task t_wake();
        key(3'h5);
        wr(8'h0F);
        chk({power_state_o, osc_run_o}, 3'h4);
        chk(sync_pin_o, 4'hF);
        chk(pwm_pin_o & pwm_en_i, pwm_en_i);
        chk(ddc_pin_oe_n_o, 2'b11);
        chk(sfr_rdata_o & 8'h0C, 8'h0C);
        i_par.wake();
        tick(8);
        chk(power_state_o, 2'b10);
        ext_b_enabled_i = 1'b1;
        i_par.wake();
        wait_st(2'b00);
        chk(power_state_o, 2'b00);
        chk(sfr_rdata_o & 8'h0C, 8'h0C);
        $display("done: wake");
    endtask : t_wake
    task t_reset();
        int r0;
        wr(8'h0E);
        r0 = n_rst;
        i_par.pulse_reset(10);
        tick(6);
        chk({n_rst != r0, power_state_o}, 3'h2);
        i_par.pulse_reset(30);
        wait_st(2'b00);
        chk({n_rst != r0, power_state_o}, 3'h4);
        chk(sfr_rdata_o, 8'h00);
        $display("done: reset");
    endtask : t_reset
    initial begin
        rst_i = 1'b1;
        sfr_addr_i = 8'h87;
        sfr_wdata_i = 8'h00;
        sfr_wr_i = 1'b0;
        sfr_rd_i = 1'b0;
        key(3'h0);
        wdog_overflow_i = 1'b0;
        irq_pending_i = 1'b0;
        ext_b_level_mode_i = 1'b1;
        ext_b_enabled_i = 1'b0;
        dac_freeze_i = 1'b1;
        display_channel_pin_enable_i = 1'b1;
        ddc_mode_active_i = 1'b0;
        sync_out_sel_i = 1'b1;
        pat_clamp_sel_i = 1'b0;
        pwm_en_i = 11'h5AA;
        pwm_val_i = 11'h30F;
        pwm_port_val_i = 11'h0F0;
        sync_val_i = 4'h0;
        sync_port_val_i = 4'h3;
        ddc_val_i = 2'b01;
        ddc_port_val_i = 2'b10;
        tick(16);
        rst_i = 1'b0;
        sfr_rd_i = 1'b1;
        #1;
        t_reg();
        t_idle();
        t_lock();
        t_wake();
        t_reset();
        print_verdict();
    end
    // Whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk_sys_i);
        n_fail++;
        print_verdict();
    end
endmodule : reduced_power_mode_control_bench
